/* bench/mwdc_dryer_bench.sv */
// Bench for the dryer: status reads and drive sequences.
// Assumes short minute and blink counts; inputs change on falling edges.
`timescale 1ns/1ns
module mwdc_dryer_bench;
    reg i_sys_clk = 0, i_rst = 1, run = 0, i_start_cmd = 0, i_op_blocked = 0, i_conv_failure = 0;
    reg [2:0] i_drying_enable_source = 0;
    reg [9:0] i_drying_current_limit = 10'h0c8, i_drying_voltage_limit = 10'h032;
    reg [10:0] i_drying_time_limit = 11'h001;
    reg [5:0] i_digital_input = 0;
    reg [15:0] i_reg_addr = 16'h07d7;
    reg b;
    wire [15:0] o_reg_rdata, o_remaining_minutes;
    wire o_dc_inject, o_run_led_green, o_drying_status, i_motor_stopped;
    wire [9:0] o_dc_current_avg, o_dc_voltage_limit;
    wire [10:0] o_dc_current_phase_max;
    integer num_errors = 0, n_compared = 0, cyc = 0, i, s;
    mwdc_dryer #(.MINUTE_CYCLES(20), .BLINK_CYCLES(4)) u_mwdc_dryer (.*);
    mwdc_stage_model u_mwdc_stage_model (.i_sys_clk(i_sys_clk), .i_run_req(run),
        .o_motor_stopped(i_motor_stopped));
    initial forever #20 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            complete_run;
        end
    end
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // Read answers one cycle after the address
    task rd(input [15:0] a, input [15:0] exp);
        begin
            i_reg_addr = a;
            tick(1);
            chk(o_reg_rdata, exp);
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d mismatched %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        tick(3);
        i_rst = 0;
        rd(16'h07d7, 16'h0);
        rd(16'h0000, 16'h0);
        chk(o_remaining_minutes, 16'h0);
        $display("reset test done");
        i_drying_enable_source = 3'h1;
        tick(2);
        i_digital_input = 6'h01;
        tick(4);
        rd(16'h07d7, 16'h0002);
        chk(o_remaining_minutes, 16'h0006);
        chk(o_dc_current_avg, 16'h00c8);
        chk(o_dc_current_phase_max, 16'h012c);
        chk(o_dc_voltage_limit, 16'h0032);
        chk(o_dc_inject, 16'h0001);
        b = o_run_led_green;
        tick(4);
        chk(o_run_led_green, !b);
        i = 0;
        while (o_drying_status === 1'b1 && i < 200) begin
            tick(1);
            i = i + 1;
        end
        chk(i >= 90 && i <= 115, 16'h1);
        tick(10);
        chk(o_drying_status, 16'h0);
        i_digital_input = 0;
        run = 1;
        tick(4);
        i_digital_input = 6'h01;
        tick(6);
        chk(o_drying_status, 16'h0);
        run = 0;
        i_digital_input = 0;
        tick(4);
        $display("timed test done");
        i_drying_time_limit = 11'h7d0;
        i_drying_enable_source = 3'h7;
        tick(6);
        chk(o_drying_status, 16'h1);
        chk(o_remaining_minutes, 16'h2ee0);
        i_drying_current_limit = 10'h3ff;
        tick(2);
        chk(o_dc_current_avg, 16'h0258);
        chk(o_drying_status, 16'h1);
        i_start_cmd = 1;
        tick(1);
        i_start_cmd = 0;
        tick(2);
        chk(o_remaining_minutes, 16'h0);
        $display("endless test done");
        for (s = 0; s < 8; s = s + 1) begin
            i_drying_enable_source = s[2:0];
            tick(4);
            i_digital_input = 6'h3f;
            tick(5);
            chk(o_drying_status, s != 0);
            i_op_blocked = (s % 3 == 1);
            i_conv_failure = (s % 3 == 2);
            i_digital_input = (s % 3 == 0) ? 6'h00 : 6'h3f;
            tick(6);
            chk(o_drying_status, 16'h0);
            i_op_blocked = 0;
            i_conv_failure = 0;
            i_digital_input = 0;
        end
        $display("source test done");
        complete_run;
    end
endmodule

/* bench/mwdc_dryer_sva.sv */
// Checker on the dryer ports.
// Assumes it is bound onto every dryer instance.
`timescale 1ns/1ns
module mwdc_dryer_sva (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_motor_stopped,
    input wire i_start_cmd,
    input wire i_op_blocked,
    input wire i_conv_failure,
    input wire [15:0] i_reg_addr,
    input wire [15:0] o_reg_rdata,
    input wire o_dc_inject,
    input wire [9:0] o_dc_current_avg,
    input wire [10:0] o_dc_current_phase_max,
    input wire [9:0] o_dc_voltage_limit,
    input wire o_run_led_green,
    input wire o_drying_status,
    input wire [15:0] o_remaining_minutes
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_inject_status: assert property (o_dc_inject == o_drying_status)
        else $error("inject and status differ");
    a_status_read: assert property (o_reg_rdata == (($past(i_reg_addr) == 16'h07d7) ?
        {14'h0, o_drying_status, 1'b0} : 16'h0)) else $error("status word wrong");
    a_idle_zero: assert property (!o_dc_inject |-> o_dc_current_avg == 0
        && o_dc_voltage_limit == 0) else $error("limits out while idle");
    a_limit_clamp: assert property (o_dc_inject |-> o_dc_current_avg <= 10'h258
        && o_dc_voltage_limit <= 10'h190) else $error("limit above clamp");
    a_phase_ratio: assert property (o_dc_current_phase_max ==
        {1'b0, o_dc_current_avg} + {2'b0, o_dc_current_avg[9:1]}) else $error("phase max");
    a_start_aborts: assert property (i_start_cmd |-> ##2 !o_drying_status
        && o_remaining_minutes == 0) else $error("start did not abort");
    a_fault_aborts: assert property (i_op_blocked || i_conv_failure || !i_motor_stopped
        |-> ##2 !o_drying_status) else $error("fault did not abort");
    a_led_idle: assert property (!o_drying_status |-> !o_run_led_green)
        else $error("led lit while idle");
    a_start_stopped: assert property ($rose(o_drying_status)
        |-> $past(i_motor_stopped, 2)) else $error("started while running");
endmodule
bind mwdc_dryer mwdc_dryer_sva u_sva (.*);

/* bench/mwdc_stage_model.sv */
// Power stage stand-in: reports the shaft state to the dryer.
// Assumes the bench asks for running through i_run_req.
`timescale 1ns/1ns
module mwdc_stage_model (
    // Clock and request
    input wire i_sys_clk,
    input wire i_run_req,
    // Shaft state
    output reg o_motor_stopped = 1'b1
);
    // One cycle late, like a real speed estimate
    always @(posedge i_sys_clk) begin
        o_motor_stopped <= !i_run_req;
    end
endmodule

/* logic/mwdc_defs.vh */
// Constants for the motor winding dryer controller.
// Assumes settings in tenths of a percent and tenths of an hour.
`ifndef MWDC_DEFS_VH
`define MWDC_DEFS_VH

// ==============================
// Register map
`define MWDC_STATUS_ADDR 16'h07d7
`define MWDC_STATUS_DRY_BIT 1

// ==============================
// Enable source codes
`define MWDC_SRC_ALWAYS_OFF 3'h0
`define MWDC_SRC_INPUT_ONE 3'h1
`define MWDC_SRC_INPUT_SIX 3'h6
`define MWDC_SRC_ALWAYS_ON 3'h7

// ==============================
// Limits and defaults, tenths of a percent
`define MWDC_CUR_MAX 10'h258
`define MWDC_CUR_DEF 10'h0c8
`define MWDC_VOLT_MAX 10'h190
`define MWDC_VOLT_DEF 10'h032

// ==============================
// Drying time, tenths of an hour
`define MWDC_TIME_MIN 11'h001
`define MWDC_TIME_TOP 11'h7d0
`define MWDC_TIME_DEF 11'h001
`define MWDC_MIN_PER_TENTH 16'h0006

// ==============================
// Timing: one minute at 25 MHz
`define MWDC_CLK_HZ 25000000
`define MWDC_MINUTE_S 60
`define MWDC_MINUTE_CYCLES (`MWDC_CLK_HZ * `MWDC_MINUTE_S)
`define MWDC_BLINK_CYCLES 12500000

`endif

/* logic/mwdc_dryer.v */
// Stopped-motor winding dryer: start/stop decision, limits and countdown.
// Assumes digital inputs come from pins; run/block/fail flags are on-clock.
`timescale 1ns/1ns
`include "mwdc_defs.vh"

module mwdc_dryer #(
    parameter MINUTE_CYCLES = `MWDC_MINUTE_CYCLES,
    parameter BLINK_CYCLES = `MWDC_BLINK_CYCLES
) (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // Settings
    input wire [2:0] i_drying_enable_source,
    input wire [9:0] i_drying_current_limit,
    input wire [9:0] i_drying_voltage_limit,
    input wire [10:0] i_drying_time_limit,
    // Pins and drive state
    input wire [5:0] i_digital_input,
    input wire i_motor_stopped,
    input wire i_start_cmd,
    input wire i_op_blocked,
    input wire i_conv_failure,
    // Status register read port
    input wire [15:0] i_reg_addr,
    output reg [15:0] o_reg_rdata,
    // Power stage requests
    output reg o_dc_inject,
    output reg [9:0] o_dc_current_avg,
    output reg [10:0] o_dc_current_phase_max,
    output reg [9:0] o_dc_voltage_limit,
    // Indicators and internal signals
    output reg o_run_led_green,
    output reg o_drying_status,
    output reg [15:0] o_remaining_minutes
);

    localparam ST_IDLE = 1'b0;
    localparam ST_DRY = 1'b1;

    // ==============================
    // Input synchronisers
    reg [5:0] di_meta;
    reg [5:0] di_sync;

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            di_meta <= 6'h00;
            di_sync <= 6'h00;
        end else begin
            di_meta <= i_digital_input;
            di_sync <= di_meta;
        end
    end

    // ==============================
    // Enable source and edge
    function sel_enable;
        input [2:0] src;
        input [5:0] di;
        begin
            case (src)
                `MWDC_SRC_ALWAYS_OFF: sel_enable = 1'b0;
                `MWDC_SRC_ALWAYS_ON: sel_enable = 1'b1;
                default: sel_enable = di[src - 3'h1];
            endcase
        end
    endfunction

    wire enable_now = sel_enable(i_drying_enable_source, di_sync);
    reg enable_prev;
    wire enable_rise = enable_now & ~enable_prev;

    // ==============================
    // Settings clamps, read live so current and voltage changes apply mid-drying
    function [9:0] clamp_top;
        input [9:0] value;
        input [9:0] top;
        begin
            if (value > top) begin
                clamp_top = top;
            end else begin
                clamp_top = value;
            end
        end
    endfunction

    wire [9:0] cur_lim = clamp_top(i_drying_current_limit, `MWDC_CUR_MAX);
    wire [9:0] volt_lim = clamp_top(i_drying_voltage_limit, `MWDC_VOLT_MAX);
    wire [10:0] time_set = (i_drying_time_limit < `MWDC_TIME_MIN) ? `MWDC_TIME_MIN :
        (i_drying_time_limit > `MWDC_TIME_TOP) ? `MWDC_TIME_TOP :
        i_drying_time_limit;
    wire endless = (time_set == `MWDC_TIME_TOP);
    wire [15:0] load_minutes = {5'h00, time_set} * `MWDC_MIN_PER_TENTH;

    // ==============================
    // Control state
    reg state;
    reg [31:0] presc;
    reg [31:0] blink_cnt;
    reg blink;
    wire minute_tick = (presc == MINUTE_CYCLES - 1);
    wire abort = i_start_cmd | ~enable_now | i_op_blocked | i_conv_failure;
    // Edge alone is not enough: refused while running, blocked or failed
    wire start_ok = enable_rise & i_motor_stopped &
        ~i_op_blocked & ~i_conv_failure;

    // ==============================
    // Next-state logic
    reg next_state;
    reg [15:0] next_remaining;

    always @* begin
        next_state = state;
        next_remaining = o_remaining_minutes;
        case (state)
            ST_IDLE: begin
                if (i_start_cmd) begin
                    next_remaining = 16'h0000;
                end else if (start_ok) begin
                    next_state = ST_DRY;
                    next_remaining = load_minutes;
                end
            end
            ST_DRY: begin
                // A turning rotor also ends drying: no DC into a spinning motor
                if (abort || !i_motor_stopped) begin
                    next_state = ST_IDLE;
                    if (i_start_cmd) begin
                        next_remaining = 16'h0000;
                    end
                end else if (minute_tick) begin
                    if (o_remaining_minutes > 16'h0001) begin
                        next_remaining = o_remaining_minutes - 16'h0001;
                    end else begin
                        next_remaining = 16'h0000;
                        if (!endless) begin
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            enable_prev <= 1'b0;
            presc <= 32'h0;
            o_remaining_minutes <= 16'h0000;
        end else begin
            enable_prev <= enable_now;
            presc <= (state == ST_IDLE || minute_tick) ? 32'h0 : presc + 32'h1;
            state <= next_state;
            o_remaining_minutes <= next_remaining;
        end
    end

    // ==============================
    // Flashing run indicator
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
        end else if (state == ST_IDLE) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
        end else if (blink_cnt == BLINK_CYCLES - 1) begin
            blink_cnt <= 32'h0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // ==============================
    // Registered outputs
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_dc_inject <= 1'b0;
            o_dc_current_avg <= 10'h000;
            o_dc_current_phase_max <= 11'h000;
            o_dc_voltage_limit <= 10'h000;
            o_run_led_green <= 1'b0;
            o_drying_status <= 1'b0;
            o_reg_rdata <= 16'h0000;
        end else begin
            o_dc_inject <= state;
            o_dc_current_avg <= state ? cur_lim : 10'h000;
            // Worst single phase, 1.5 times the average bound
            o_dc_current_phase_max <= state ?
                ({1'b0, cur_lim} + {2'b00, cur_lim[9:1]}) : 11'h000;
            o_dc_voltage_limit <= state ? volt_lim : 10'h000;
            o_run_led_green <= state & blink;
            o_drying_status <= state;
            o_reg_rdata <= (i_reg_addr == `MWDC_STATUS_ADDR) ?
                {14'h0000, state, 1'b0} : 16'h0000;
        end
    end

endmodule
